// ==== design/cwo_pkg.sv ====
// Constants for the complementary wave output-mode block
package cwo_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int DB_W = 6;
  localparam int N_OUT = 4;
  // Register indices
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_POLARITY = 4'h1;
  localparam logic [3:0] REG_STEER = 4'h2;
  localparam logic [3:0] REG_RISE_DB = 4'h3;
  localparam logic [3:0] REG_FALL_DB = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h5;
  // Register field positions
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_CS_BIT = 3;
  localparam int CTRL_MODE_LSB = 0;
  localparam int STEER_SEL_LSB = 0;
  localparam int STEER_OVR_LSB = 4;
  localparam int STAT_OUT_LSB = 0;
  localparam int STAT_PHASE_BIT = 4;
  localparam int STAT_DIR_BIT = 5;
  localparam int STAT_HOLD_BIT = 6;
  // Mode encodings
  localparam logic [2:0] MODE_STEER_ASYNC = 3'h0;
  localparam logic [2:0] MODE_STEER_SYNC = 3'h1;
  localparam logic [2:0] MODE_FB_FWD = 3'h2;
  localparam logic [2:0] MODE_FB_REV = 3'h3;
  localparam logic [2:0] MODE_HALF = 3'h4;
  localparam logic [2:0] MODE_PUSH_PULL = 3'h5;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [3:0] POLARITY_RST = 4'h0;
  localparam logic [3:0] STEER_RST = 4'h0;
  localparam logic [3:0] OVR_RST = 4'h0;
  localparam logic [5:0] DB_RST = 6'h00;
endpackage : cwo_pkg

// ==== design/cwo_db_counter.sv ====
// Dead-band counter: counts timing ticks from zero up to a limit
`timescale 1ns/1ns
module cwo_db_counter
  import cwo_pkg::*;
#(
  parameter int W = DB_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic tick,
  input wire logic [W-1:0] limit,
  output logic done
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } cwo_dbc_state_t;

  cwo_dbc_state_t st_r;
  cwo_dbc_state_t st_nxt;

  // Restart from zero whenever the run condition drops
  always_comb begin
    st_nxt = st_r;
    if (!run) begin
      st_nxt.cnt = '0;
    end else if (tick && (st_r.cnt < limit)) begin
      st_nxt.cnt = W'(st_r.cnt + 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Limit of zero raises done together with run; a full-bridge swap gap still lasts one cycle
  assign done = run && (st_r.cnt == limit);

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_DB_NEVER_PAST_LIMIT: assert property (
    run && (st_r.cnt <= limit) |=> (st_r.cnt <= $past(limit))
  ) else $error("dead-band count ran past its limit");
endmodule : cwo_db_counter

// ==== design/cwo_wave_modes.sv ====
// Output-mode logic of the complementary wave generator
`timescale 1ns/1ns
module cwo_wave_modes
  import cwo_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic DATA_IN,
  input wire logic SHUTDOWN_ACT,
  input wire logic SLEEP,
  input wire logic FAST_OSC_TICK,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output logic [DATA_W-1:0] RDATA,
  output logic BRIDGE_OUT_FIRST,
  output logic BRIDGE_OUT_SECOND,
  output logic BRIDGE_OUT_THIRD,
  output logic BRIDGE_OUT_FOURTH
);
  typedef struct packed {
    logic ctrl_en;
    logic clk_sel;
    logic [2:0] mode;
    logic [N_OUT-1:0] out_polarity;
    logic [N_OUT-1:0] steer_sel;
    logic [N_OUT-1:0] override_level;
    logic [DB_W-1:0] rise_db;
    logic [DB_W-1:0] fall_db;
    logic [N_OUT-1:0] steer_eff;
    logic data_prev;
    logic pp_phase;
    logic fb_dir;
    logic fb_hold;
    logic [N_OUT-1:0] out;
    logic [DATA_W-1:0] rdata;
  } cwo_state_t;

  cwo_state_t st_r;
  cwo_state_t st_nxt;

  logic is_half;
  logic is_fb;
  logic is_steer;
  logic running;
  logic db_tick;
  logic rise_run;
  logic fall_run;
  logic rise_done;
  logic fall_done;
  logic data_rise;
  logic data_fall;

  // Mode decode and run conditions
  assign is_half = (st_r.mode == MODE_HALF);
  assign is_fb = (st_r.mode == MODE_FB_FWD) || (st_r.mode == MODE_FB_REV);
  assign is_steer = (st_r.mode == MODE_STEER_ASYNC) || (st_r.mode == MODE_STEER_SYNC);
  assign running = st_r.ctrl_en && !SHUTDOWN_ACT;
  assign data_rise = DATA_IN && !st_r.data_prev;
  assign data_fall = !DATA_IN && st_r.data_prev;

  // System clock halts in sleep; fast oscillator keeps ticking
  assign db_tick = st_r.clk_sel ? FAST_OSC_TICK : !SLEEP;

  // Half-bridge times edges; full-bridge only times direction swaps
  assign rise_run = running && (is_half ? DATA_IN : (is_fb && st_r.fb_hold && st_r.fb_dir));
  assign fall_run = running && (is_half ? !DATA_IN : (is_fb && st_r.fb_hold && !st_r.fb_dir));

  // Rising counter: half-bridge turn-on of first, reverse swap gap
  cwo_db_counter #(
    .W(DB_W)
  ) u_rise_db (
    .clk(REF_CLK),
    .rst_n(RESETN),
    .run(rise_run),
    .tick(db_tick),
    .limit(st_r.rise_db),
    .done(rise_done)
  );

  // Falling counter: half-bridge turn-on of second, forward swap gap
  cwo_db_counter #(
    .W(DB_W)
  ) u_fall_db (
    .clk(REF_CLK),
    .rst_n(RESETN),
    .run(fall_run),
    .tick(db_tick),
    .limit(st_r.fall_db),
    .done(fall_done)
  );

  // Register file, mode sequencing and output shaping
  always_comb begin
    logic [N_OUT-1:0] act;
    logic modulated;
    act = '0;
    modulated = 1'b0;
    st_nxt = st_r;
    st_nxt.rdata = '0;
    st_nxt.data_prev = DATA_IN;

    // Software writes; mode changes are expected only while disabled
    if (WR_STB) begin
      if (ADDR == REG_CTRL) begin
        st_nxt.ctrl_en = WDATA[CTRL_EN_BIT];
        st_nxt.clk_sel = WDATA[CTRL_CS_BIT];
        st_nxt.mode = WDATA[CTRL_MODE_LSB +: 3];
      end else if (ADDR == REG_POLARITY) begin
        st_nxt.out_polarity = WDATA[N_OUT-1:0];
      end else if (ADDR == REG_STEER) begin
        st_nxt.steer_sel = WDATA[STEER_SEL_LSB +: N_OUT];
        st_nxt.override_level = WDATA[STEER_OVR_LSB +: N_OUT];
      end else if (ADDR == REG_RISE_DB) begin
        st_nxt.rise_db = WDATA[DB_W-1:0];
      end else if (ADDR == REG_FALL_DB) begin
        st_nxt.fall_db = WDATA[DB_W-1:0];
      end
    end

    // Reads answer in the next cycle; unmapped reads give zero
    if (RD_STB) begin
      if (ADDR == REG_CTRL) begin
        st_nxt.rdata[CTRL_EN_BIT] = st_r.ctrl_en;
        st_nxt.rdata[CTRL_CS_BIT] = st_r.clk_sel;
        st_nxt.rdata[CTRL_MODE_LSB +: 3] = st_r.mode;
      end else if (ADDR == REG_POLARITY) begin
        st_nxt.rdata[N_OUT-1:0] = st_r.out_polarity;
      end else if (ADDR == REG_STEER) begin
        st_nxt.rdata[STEER_SEL_LSB +: N_OUT] = st_r.steer_sel;
        st_nxt.rdata[STEER_OVR_LSB +: N_OUT] = st_r.override_level;
      end else if (ADDR == REG_RISE_DB) begin
        st_nxt.rdata[DB_W-1:0] = st_r.rise_db;
      end else if (ADDR == REG_FALL_DB) begin
        st_nxt.rdata[DB_W-1:0] = st_r.fall_db;
      end else if (ADDR == REG_STATUS) begin
        st_nxt.rdata[STAT_OUT_LSB +: N_OUT] = st_r.out;
        st_nxt.rdata[STAT_PHASE_BIT] = st_r.pp_phase;
        st_nxt.rdata[STAT_DIR_BIT] = st_r.fb_dir;
        st_nxt.rdata[STAT_HOLD_BIT] = st_r.fb_hold;
      end
    end

    // Push-pull sequencer: cleared when idle, advances after each pulse
    if (!running) begin
      st_nxt.pp_phase = 1'b0;
    end else if ((st_r.mode == MODE_PUSH_PULL) && data_fall) begin
      st_nxt.pp_phase = !st_r.pp_phase;
    end

    // Full-bridge direction: loaded freely while disabled or in other modes, else at a rise
    if (!st_r.ctrl_en || !is_fb) begin
      // Next mode, so an enabling write starts in the written direction
      st_nxt.fb_dir = st_nxt.mode[0];
      st_nxt.fb_hold = 1'b0;
    end else if (data_rise && (st_r.mode[0] != st_r.fb_dir)) begin
      st_nxt.fb_dir = st_r.mode[0];
      st_nxt.fb_hold = 1'b1;
    end else if (st_r.fb_hold && (st_r.fb_dir ? rise_done : fall_done)) begin
      st_nxt.fb_hold = 1'b0;
    end

    // Steering selection: async follows the register, sync waits for a rise
    if (!st_r.ctrl_en || (st_r.mode == MODE_STEER_ASYNC)) begin
      st_nxt.steer_eff = st_r.steer_sel;
    end else if ((st_r.mode == MODE_STEER_SYNC) && data_rise) begin
      st_nxt.steer_eff = st_r.steer_sel;
    end

    // Active-level pattern for the bridge modes
    case (st_r.mode)
      MODE_HALF: begin
        act[0] = DATA_IN && rise_done;
        act[1] = !DATA_IN && fall_done;
        act[2] = act[0];
        act[3] = act[1];
      end
      MODE_PUSH_PULL: begin
        act[0] = DATA_IN && !st_r.pp_phase;
        act[1] = DATA_IN && st_r.pp_phase;
        act[2] = act[0];
        act[3] = act[1];
      end
      MODE_FB_FWD, MODE_FB_REV: begin
        // Modulated leg stays off through the swap gap
        modulated = DATA_IN && !st_nxt.fb_hold;
        if (!st_nxt.fb_dir) begin
          act = {modulated, 1'b0, 1'b0, 1'b1};
        end else begin
          act = {1'b0, 1'b1, modulated, 1'b0};
        end
      end
      default: begin
        act = '0;
      end
    endcase

    // Output levels: disabled, steering, shutdown, then normal drive
    for (int i = 0; i < N_OUT; i++) begin
      if (!st_r.ctrl_en) begin
        st_nxt.out[i] = !st_r.out_polarity[i];
      end else if (is_steer) begin
        // Unsteered legs never see shutdown or polarity
        if (st_nxt.steer_eff[i] && !SHUTDOWN_ACT) begin
          st_nxt.out[i] = DATA_IN ^ !st_r.out_polarity[i];
        end else begin
          st_nxt.out[i] = st_r.override_level[i];
        end
      end else if (SHUTDOWN_ACT) begin
        st_nxt.out[i] = st_r.override_level[i];
      end else begin
        st_nxt.out[i] = act[i] ^ !st_r.out_polarity[i];
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      st_r <= '{
        ctrl_en: CTRL_RST[CTRL_EN_BIT],
        clk_sel: CTRL_RST[CTRL_CS_BIT],
        mode: CTRL_RST[CTRL_MODE_LSB +: 3],
        out_polarity: POLARITY_RST,
        steer_sel: STEER_RST,
        override_level: OVR_RST,
        rise_db: DB_RST,
        fall_db: DB_RST,
        steer_eff: STEER_RST,
        data_prev: 1'b0,
        pp_phase: 1'b0,
        fb_dir: 1'b0,
        fb_hold: 1'b0,
        out: ~POLARITY_RST,
        rdata: '0
      };
    end else begin
      st_r <= st_nxt;
    end
  end

  // Ports straight from the state flops
  assign RDATA = st_r.rdata;
  assign BRIDGE_OUT_FIRST = st_r.out[0];
  assign BRIDGE_OUT_SECOND = st_r.out[1];
  assign BRIDGE_OUT_THIRD = st_r.out[2];
  assign BRIDGE_OUT_FOURTH = st_r.out[3];

  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);

  AST_DISABLED_INACTIVE: assert property (
    !st_r.ctrl_en |=> (st_r.out == ~$past(st_r.out_polarity))
  ) else $error("disabled outputs not at inactive level");

  AST_HALF_NO_OVERLAP: assert property (
    running && is_half |=>
      !((st_r.out[0] == $past(st_r.out_polarity[0])) &&
        (st_r.out[1] == $past(st_r.out_polarity[1])))
  ) else $error("half-bridge outputs active together");

  AST_PP_SEQ_RESET: assert property (
    !running |=> !st_r.pp_phase
  ) else $error("push-pull sequencer not reset");

  AST_FWD_STATICS: assert property (
    running && (st_r.mode == MODE_FB_FWD) && !st_r.fb_dir && !data_rise |=>
      (st_r.out[0] == $past(st_r.out_polarity[0])) &&
      (st_r.out[1] != $past(st_r.out_polarity[1])) &&
      (st_r.out[2] != $past(st_r.out_polarity[2]))
  ) else $error("forward statics wrong");

  AST_REV_STATICS: assert property (
    running && (st_r.mode == MODE_FB_REV) && st_r.fb_dir && !data_rise |=>
      (st_r.out[2] == $past(st_r.out_polarity[2])) &&
      (st_r.out[0] != $past(st_r.out_polarity[0])) &&
      (st_r.out[3] != $past(st_r.out_polarity[3]))
  ) else $error("reverse statics wrong");

  AST_FB_SWAP_HOLDS_MOD: assert property (
    running && is_fb && data_rise && (st_r.mode[0] != st_r.fb_dir) |=>
      st_r.fb_hold && (st_r.fb_dir == $past(st_r.mode[0]))
  ) else $error("direction swap not taken at data rise");

  AST_SYNC_STEER_WAITS: assert property (
    st_r.ctrl_en && (st_r.mode == MODE_STEER_SYNC) && !data_rise |=> $stable(st_r.steer_eff)
  ) else $error("sync steering changed without data rise");

  AST_ASYNC_STEER_NOW: assert property (
    st_r.ctrl_en && (st_r.mode == MODE_STEER_ASYNC) |=> (st_r.steer_eff == $past(st_r.steer_sel))
  ) else $error("async steering did not follow register");

  AST_SHUTDOWN_OVERRIDE: assert property (
    st_r.ctrl_en && SHUTDOWN_ACT |=> (st_r.out == $past(st_r.override_level))
  ) else $error("shutdown did not apply override levels");

  // Leg patterns per mode, judged as active or inactive
  AST_HALF_MIRROR: assert property (
    running && is_half |=>
      ((st_r.out[2] == $past(st_r.out_polarity[2])) ==
        (st_r.out[0] == $past(st_r.out_polarity[0]))) &&
      ((st_r.out[3] == $past(st_r.out_polarity[3])) ==
        (st_r.out[1] == $past(st_r.out_polarity[1])))
  ) else $error("half-bridge third or fourth leg not mirrored");

  AST_HALF_OFF_LEG: assert property (
    running && is_half |=>
      ($past(DATA_IN) ? (st_r.out[1] != $past(st_r.out_polarity[1])) :
        (st_r.out[0] != $past(st_r.out_polarity[0])))
  ) else $error("half-bridge leg active against the input");

  AST_PP_MIRROR: assert property (
    running && (st_r.mode == MODE_PUSH_PULL) |=>
      ((st_r.out[2] == $past(st_r.out_polarity[2])) ==
        (st_r.out[0] == $past(st_r.out_polarity[0]))) &&
      ((st_r.out[3] == $past(st_r.out_polarity[3])) ==
        (st_r.out[1] == $past(st_r.out_polarity[1])))
  ) else $error("push-pull third or fourth leg not copied");

  AST_PP_ONE_LEG: assert property (
    running && (st_r.mode == MODE_PUSH_PULL) |=>
      !((st_r.out[0] == $past(st_r.out_polarity[0])) &&
        (st_r.out[1] == $past(st_r.out_polarity[1])))
  ) else $error("push-pull legs active together");

  AST_PP_ALTERNATE: assert property (
    running && (st_r.mode == MODE_PUSH_PULL) && data_fall |=>
      (st_r.pp_phase != $past(st_r.pp_phase))
  ) else $error("push-pull sequencer did not advance");

  AST_FB_DIR_AT_RISE: assert property (
    st_r.ctrl_en && is_fb && !data_rise |=> $stable(st_r.fb_dir)
  ) else $error("direction changed without data rise");

  AST_FB_GAP_QUIET: assert property (
    running && is_fb ##1 st_r.fb_hold |->
      (st_r.fb_dir ? (st_r.out[1] != $past(st_r.out_polarity[1])) :
        (st_r.out[3] != $past(st_r.out_polarity[3])))
  ) else $error("modulated leg active during swap gap");

  AST_FB_MOD_FOLLOWS: assert property (
    running && is_fb ##1 !st_r.fb_hold |->
      (st_r.fb_dir ?
        (st_r.out[1] == ($past(DATA_IN) ^ !$past(st_r.out_polarity[1]))) :
        (st_r.out[3] == ($past(DATA_IN) ^ !$past(st_r.out_polarity[3]))))
  ) else $error("modulated leg does not follow data");

  AST_STEER_DATA: assert property (
    st_r.ctrl_en && is_steer && !SHUTDOWN_ACT |=>
      (((st_r.out ^ ~$past(st_r.out_polarity)) & st_r.steer_eff) ==
        ({N_OUT{$past(DATA_IN)}} & st_r.steer_eff))
  ) else $error("steered leg does not carry data");

  AST_STEER_FIXED: assert property (
    st_r.ctrl_en && is_steer |=>
      ((st_r.out & ~st_r.steer_eff) == ($past(st_r.override_level) & ~st_r.steer_eff))
  ) else $error("unsteered leg not at override level");

  AST_SYNC_STEER_AT_RISE: assert property (
    st_r.ctrl_en && (st_r.mode == MODE_STEER_SYNC) && data_rise |=>
      (st_r.steer_eff == $past(st_r.steer_sel))
  ) else $error("sync steering not taken at data rise");
endmodule : cwo_wave_modes

// ==== dv/cwo_src_model.sv ====
// Far-side model: pulse source on the data input and fast oscillator ticks
`timescale 1ns/1ns
module cwo_src_model #(
  parameter int TICK_DIV = 4
) (
  input wire logic clk,
  input wire logic lvl,
  input wire logic osc_on,
  output logic data,
  output logic tick
);
  int cnt_r = 0;
  // Source level is edge-aligned already, so it passes straight through
  assign data = lvl;
  // Oscillator ignores sleep; only the bench gates it, to prove the select
  always_ff @(posedge clk) begin
    cnt_r <= (cnt_r == TICK_DIV - 1) ? 0 : cnt_r + 1;
  end
  assign tick = osc_on && (cnt_r == 0);
endmodule : cwo_src_model

// ==== dv/cwo_wave_modes_tb.sv ====
// Self-checking bench for the wave output-mode block
`timescale 1ns/1ns
module cwo_wave_modes_tb;
  logic REF_CLK, RESETN, DATA_IN, SHUTDOWN_ACT, SLEEP, FAST_OSC_TICK, WR_STB, RD_STB;
  logic lvl, osc_on;
  logic [3:0] ADDR;
  logic [7:0] WDATA, RDATA;
  logic o_first, o_second, o_third, o_fourth;
  wire [3:0] outs;
  int miscompares = 0;
  int comparisons = 0;

  // Outputs gathered first-to-fourth, most significant first
  assign outs = {o_first, o_second, o_third, o_fourth};

  cwo_wave_modes dut_u (
    .REF_CLK(REF_CLK),
    .RESETN(RESETN),
    .DATA_IN(DATA_IN),
    .SHUTDOWN_ACT(SHUTDOWN_ACT),
    .SLEEP(SLEEP),
    .FAST_OSC_TICK(FAST_OSC_TICK),
    .ADDR(ADDR),
    .WDATA(WDATA),
    .WR_STB(WR_STB),
    .RD_STB(RD_STB),
    .RDATA(RDATA),
    .BRIDGE_OUT_FIRST(o_first),
    .BRIDGE_OUT_SECOND(o_second),
    .BRIDGE_OUT_THIRD(o_third),
    .BRIDGE_OUT_FOURTH(o_fourth)
  );

  cwo_src_model src_u (
    .clk(REF_CLK),
    .lvl(lvl),
    .osc_on(osc_on),
    .data(DATA_IN),
    .tick(FAST_OSC_TICK)
  );

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic co(input logic [3:0] e);
    chk("outputs", {4'h0, outs}, {4'h0, e});
  endtask : co

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge REF_CLK);
    ADDR <= a;
    WDATA <= d;
    WR_STB <= 1'b1;
    @(posedge REF_CLK);
    WR_STB <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge REF_CLK);
    ADDR <= a;
    RD_STB <= 1'b1;
    @(posedge REF_CLK);
    RD_STB <= 1'b0;
    #1;
    chk("rdata", RDATA, e);
  endtask : rd

  // Sample just after an edge so registered outputs have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge REF_CLK);
    #1;
  endtask : cyc

  task automatic dat(input logic v);
    @(posedge REF_CLK);
    lvl <= v;
  endtask : dat

  task automatic pulse(input logic [3:0] e);
    dat(1'b1);
    cyc(2);
    co(e);
    dat(1'b0);
    cyc(2);
    co(4'h0);
  endtask : pulse

  task automatic complete_run;
    if (miscompares == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  // Free-running reference clock
  initial begin
    REF_CLK = 1'b0;
    forever #5 REF_CLK = ~REF_CLK;
  end

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #200000;
    miscompares++;
    complete_run();
  end

  initial begin
    RESETN = 1'b0;
    lvl = 1'b0;
    osc_on = 1'b0;
    SHUTDOWN_ACT = 1'b0;
    SLEEP = 1'b0;
    ADDR = 4'h0;
    WDATA = 8'h00;
    WR_STB = 1'b0;
    RD_STB = 1'b0;
    repeat (3) @(posedge REF_CLK);
    RESETN <= 1'b1;
    // Reset values, unmapped read, idle outputs
    for (int i = 0; i < 5; i++) rd(i[3:0], 8'h00);
    rd(4'h5, 8'h0f);
    rd(4'hf, 8'h00);
    co(4'hf);
    // Half-bridge with rise 3, fall 5
    wr(4'h1, 8'h0f);
    wr(4'h3, 8'h03);
    wr(4'h4, 8'h05);
    wr(4'h0, 8'h84);
    rd(4'h3, 8'h03);
    cyc(10);
    co(4'b0101);
    dat(1'b1);
    cyc(2);
    co(4'b0000);
    cyc(6);
    co(4'b1010);
    dat(1'b0);
    cyc(2);
    co(4'b0000);
    cyc(8);
    co(4'b0101);
    wr(4'h1, 8'h03);
    cyc(2);
    co(4'b0110);
    wr(4'h0, 8'h04);
    cyc(2);
    co(4'b0011);
    // Fast oscillator timing while asleep
    wr(4'h0, 8'h8c);
    @(posedge REF_CLK);
    SLEEP <= 1'b1;
    dat(1'b1);
    cyc(20);
    co(4'b0011);
    @(posedge REF_CLK);
    osc_on <= 1'b1;
    cyc(20);
    co(4'b1001);
    @(posedge REF_CLK);
    osc_on <= 1'b0;
    SLEEP <= 1'b0;
    dat(1'b0);
    // Push-pull, no dead band; disable first, keeping the mode
    wr(4'h0, 8'h04);
    wr(4'h1, 8'h0f);
    wr(4'h3, 8'h00);
    wr(4'h4, 8'h00);
    wr(4'h0, 8'h85);
    pulse(4'b1010);
    pulse(4'b0101);
    pulse(4'b1010);
    // Sequencer points at second now, so only a reset gives first
    @(posedge REF_CLK);
    SHUTDOWN_ACT <= 1'b1;
    cyc(2);
    @(posedge REF_CLK);
    SHUTDOWN_ACT <= 1'b0;
    pulse(4'b1010);
    // Again on second before the disable
    wr(4'h0, 8'h05);
    wr(4'h0, 8'h85);
    pulse(4'b1010);
    // Full-bridge with direction dead band of 6
    wr(4'h0, 8'h05);
    wr(4'h3, 8'h06);
    wr(4'h4, 8'h06);
    wr(4'h0, 8'h82);
    cyc(2);
    co(4'b1000);
    dat(1'b1);
    cyc(2);
    co(4'b1001);
    dat(1'b0);
    wr(4'h0, 8'h83);
    cyc(4);
    co(4'b1000);
    dat(1'b1);
    cyc(2);
    co(4'b0010);
    cyc(10);
    co(4'b0110);
    rd(4'h5, 8'h26);
    dat(1'b0);
    cyc(2);
    co(4'b0010);
    dat(1'b1);
    cyc(2);
    co(4'b0110);
    dat(1'b0);
    wr(4'h0, 8'h82);
    dat(1'b1);
    cyc(2);
    co(4'b1000);
    cyc(10);
    co(4'b1001);
    dat(1'b0);
    // Asynchronous steering: first and third steered
    wr(4'h0, 8'h02);
    wr(4'h2, 8'ha5);
    rd(4'h2, 8'ha5);
    wr(4'h0, 8'h80);
    cyc(2);
    co(4'b0101);
    dat(1'b1);
    cyc(2);
    co(4'b1111);
    wr(4'h1, 8'h00);
    cyc(2);
    co(4'b0101);
    wr(4'h1, 8'h0f);
    @(posedge REF_CLK);
    SHUTDOWN_ACT <= 1'b1;
    cyc(2);
    co(4'b0101);
    @(posedge REF_CLK);
    SHUTDOWN_ACT <= 1'b0;
    wr(4'h2, 8'ha4);
    cyc(2);
    co(4'b0111);
    dat(1'b0);
    // Synchronous steering
    wr(4'h0, 8'h00);
    wr(4'h2, 8'ha5);
    wr(4'h0, 8'h81);
    dat(1'b1);
    cyc(2);
    co(4'b1111);
    wr(4'h2, 8'h84);
    cyc(3);
    co(4'b1011);
    dat(1'b0);
    cyc(2);
    co(4'b0001);
    dat(1'b1);
    cyc(2);
    co(4'b0011);
    complete_run();
  end
endmodule : cwo_wave_modes_tb
